// ==== logic/mal_pkg.sv ====
// constants, op codes and state carriers of the instruction subset unit
package mal_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CMD   = 8'h00;
    localparam logic [7:0] ADDR_OPND  = 8'h04;
    localparam logic [7:0] ADDR_ACC   = 8'h08;
    localparam logic [7:0] ADDR_STAT  = 8'h0c;
    localparam logic [7:0] ADDR_PC    = 8'h10;
    localparam logic [7:0] ADDR_TBL   = 8'h14;
    localparam logic [7:0] ADDR_MADDR = 8'h18;
    localparam logic [7:0] ADDR_MDATA = 8'h1c;
    localparam logic [7:0] ADDR_PADDR = 8'h20;
    localparam logic [7:0] ADDR_PDATA = 8'h24;
    localparam logic [7:0] ADDR_WDOG  = 8'h28;
    localparam logic [7:0] ADDR_CYC   = 8'h2c;
    // field positions
    localparam int CMD_BIT_LSB  = 8;
    localparam int OPND_IMM_LSB = 8;
    localparam int OPND_TGT_LSB = 16;
    localparam int TBL_PAGE_LSB = 8;
    localparam int TBL_HIGH_LSB = 16;
    localparam int ST_C   = 0;
    localparam int ST_AUX = 1;
    localparam int ST_Z   = 2;
    localparam int ST_OVF = 3;
    localparam int ST_SGN = 4;
    localparam int ST_WTO = 5;
    localparam int ST_PDN = 6;
    localparam int ST_BSY = 8;
    localparam int ST_HLT = 9;
    localparam int ST_SKP = 10;
    // data address that aliases the low program counter byte
    localparam logic [7:0] PC_LOW_ADDR = 8'h06;
    localparam logic [1:0] LAST_PAGE   = 2'h3;
    // reset values
    localparam logic [7:0]  ACC_RST  = 8'h00;
    localparam logic [9:0]  PC_RST   = 10'h000;
    localparam logic [15:0] WDOG_RST = 16'h0000;
    // cycle counts
    localparam logic [1:0] CYC_ONE   = 2'h1;
    localparam logic [1:0] CYC_TWO   = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;

    typedef enum logic [5:0] {
        op_nop, op_ext_zero_skip, op_ext_zero_skip_move_op, op_ext_nonzero_skip,
        op_ext_bit_zero_skip, op_ext_bit_set_skip, op_ext_increment_skip_op,
        op_ext_decrement_skip_op, op_ext_inc_skip_acc, op_ext_dec_skip_acc,
        op_ext_table_read_op, op_ext_table_read_last, op_ext_preinc_table_read_op,
        op_ext_preinc_table_read_last, op_ext_clear, op_ext_set, op_ext_nibble_swap_op,
        op_ext_nibble_swap_acc, op_add_carry, op_add_carry_to_memory_op, op_add,
        op_add_to_memory, op_add_imm, op_and, op_and_to_memory, op_and_imm, op_call,
        op_clear, op_clear_bit, op_clear_watchdog, op_complement, op_complement_to_acc_op,
        op_decimal_adjust_op, op_decrement, op_decrement_to_acc, op_power_down
    } mal_op_type;

    typedef struct packed {
        logic carry_flag;
        logic auxiliary_carry_flag;
        logic zero_flag;
        logic overflow_flag;
        logic signed_carry_flag;
        logic watchdog_timeout_flag;
        logic power_down_flag;
    } mal_flags_type;

    typedef struct packed {
        logic [7:0]       acc;
        mal_flags_type    fl;
        logic [9:0]       pc;
        logic [7:0]       table_pointer;
        logic [1:0]       table_page;
        logic [7:0]       table_high_latch;
        logic [1:0]       sp;
        logic [3:0][9:0]  stack;
        logic [15:0]      watchdog_counter;
        logic             busy;
        logic [1:0]       cnt;
        mal_op_type       op;
        logic [7:0]       m;
        logic [7:0]       imm;
        logic [2:0]       bsel;
        logic [9:0]       target;
        logic             halted;
        logic             skip;
        logic [1:0]       cyc;
        logic             pready;
        logic [31:0]      prdata;
        logic             pslverr;
        logic [7:0]       maddr;
        logic [9:0]       pmaddr;
    } mal_state_type;
endpackage : mal_pkg

// ==== logic/mal_core.sv ====
// instruction subset execution unit with apb register access
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ps
module mal_core (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    output logic             busy,
    output logic             halted
);
    mal_pkg::mal_state_type st;
    mal_pkg::mal_state_type nx;

    logic [7:0]  dmem [256];
    logic [15:0] pmem [1024];

    logic        dm_we;
    logic [7:0]  dm_wa;
    logic [7:0]  dm_wd;
    logic        pm_we;
    logic [7:0]  mval;
    logic [7:0]  opb;
    logic        cin;
    logic [8:0]  add9;
    logic [4:0]  add5;
    logic        ovf;
    logic [7:0]  res;
    logic        wr_acc;
    logic        wr_mem;
    logic        arith;
    logic        zflag;
    logic        skip;
    logic        ext;
    logic        tbl;
    logic        pre;
    logic [7:0]  tptr;
    logic [15:0] tword;
    logic [1:0]  cycles;
    logic        done;
    logic        lo_adj;
    logic        hi_adj;
    logic        access;
    logic        cmd_ok;
    logic [9:0]  pc_inc;

    ////////////////////////////////////////////////////////////////////////////
    // operand and arithmetic datapath

    // pc low address reads the live counter
    assign mval  = (st.m == mal_pkg::PC_LOW_ADDR) ? st.pc[7:0] : dmem[st.m];
    assign opb   = (st.op == mal_pkg::op_add_imm || st.op == mal_pkg::op_and_imm) ? st.imm : mval;
    assign cin   = (st.op == mal_pkg::op_add_carry ||
                    st.op == mal_pkg::op_add_carry_to_memory_op) ? st.fl.carry_flag : 1'b0;
    assign add9  = {1'b0, st.acc} + {1'b0, opb} + {8'h00, cin};
    assign add5  = {1'b0, st.acc[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
    assign ovf   = (st.acc[7] == opb[7]) && (add9[7] != st.acc[7]);
    assign lo_adj = (st.acc[3:0] > 4'h9) || st.fl.auxiliary_carry_flag;
    assign hi_adj = (st.acc[7:4] > 4'h9) || st.fl.carry_flag;
    assign pre   = (st.op == mal_pkg::op_ext_preinc_table_read_op ||
                    st.op == mal_pkg::op_ext_preinc_table_read_last);
    assign tptr  = pre ? st.table_pointer + 8'h01 : st.table_pointer;
    assign tword = (st.op == mal_pkg::op_ext_table_read_op || st.op == mal_pkg::op_ext_preinc_table_read_op)
                 ? pmem[{st.table_page, tptr}] : pmem[{mal_pkg::LAST_PAGE, tptr}];
    assign ext   = (st.op != mal_pkg::op_nop) && (st.op <= mal_pkg::op_ext_nibble_swap_acc);
    assign pc_inc = st.pc + 10'h001;
    assign access = psel && penable && !st.pready;
    assign cmd_ok = !st.busy && !st.halted;

    always_comb begin
        res    = 8'h00;
        wr_acc = 1'b0;
        wr_mem = 1'b0;
        arith  = 1'b0;
        zflag  = 1'b0;
        skip   = 1'b0;
        tbl    = 1'b0;
        case (st.op)
            mal_pkg::op_ext_zero_skip:         skip = (mval == 8'h00);
            mal_pkg::op_ext_nonzero_skip:      skip = (mval != 8'h00);
            mal_pkg::op_ext_zero_skip_move_op: begin
                res    = mval;
                wr_acc = 1'b1;
                skip   = (mval == 8'h00);
            end
            mal_pkg::op_ext_bit_zero_skip:     skip = !mval[st.bsel];
            mal_pkg::op_ext_bit_set_skip:      skip = mval[st.bsel];
            mal_pkg::op_ext_increment_skip_op, mal_pkg::op_ext_inc_skip_acc: begin
                res    = mval + 8'h01;
                wr_mem = (st.op == mal_pkg::op_ext_increment_skip_op);
                wr_acc = !wr_mem;
                skip   = (res == 8'h00);
            end
            mal_pkg::op_ext_decrement_skip_op, mal_pkg::op_ext_dec_skip_acc: begin
                res    = mval - 8'h01;
                wr_mem = (st.op == mal_pkg::op_ext_decrement_skip_op);
                wr_acc = !wr_mem;
                skip   = (res == 8'h00);
            end
            mal_pkg::op_ext_table_read_op, mal_pkg::op_ext_table_read_last,
            mal_pkg::op_ext_preinc_table_read_op, mal_pkg::op_ext_preinc_table_read_last: begin
                res    = tword[7:0];
                wr_mem = 1'b1;
                tbl    = 1'b1;
            end
            mal_pkg::op_ext_clear, mal_pkg::op_clear: begin
                res    = 8'h00;
                wr_mem = 1'b1;
            end
            mal_pkg::op_ext_set: begin
                res    = 8'hff;
                wr_mem = 1'b1;
            end
            mal_pkg::op_ext_nibble_swap_op, mal_pkg::op_ext_nibble_swap_acc: begin
                res    = {mval[3:0], mval[7:4]};
                wr_mem = (st.op == mal_pkg::op_ext_nibble_swap_op);
                wr_acc = !wr_mem;
            end
            mal_pkg::op_add_carry, mal_pkg::op_add, mal_pkg::op_add_imm: begin
                res    = add9[7:0];
                wr_acc = 1'b1;
                arith  = 1'b1;
            end
            mal_pkg::op_add_carry_to_memory_op, mal_pkg::op_add_to_memory: begin
                res    = add9[7:0];
                wr_mem = 1'b1;
                arith  = 1'b1;
            end
            mal_pkg::op_and, mal_pkg::op_and_imm, mal_pkg::op_and_to_memory: begin
                res    = st.acc & opb;
                wr_mem = (st.op == mal_pkg::op_and_to_memory);
                wr_acc = !wr_mem;
                zflag  = 1'b1;
            end
            mal_pkg::op_clear_bit: begin
                res    = mval & ~(8'h01 << st.bsel);
                wr_mem = 1'b1;
            end
            mal_pkg::op_complement, mal_pkg::op_complement_to_acc_op: begin
                res    = ~mval;
                wr_mem = (st.op == mal_pkg::op_complement);
                wr_acc = !wr_mem;
                zflag  = 1'b1;
            end
            mal_pkg::op_decimal_adjust_op: begin
                res    = st.acc + {(hi_adj ? 4'h6 : 4'h0), (lo_adj ? 4'h6 : 4'h0)};
                wr_mem = 1'b1;
            end
            mal_pkg::op_decrement, mal_pkg::op_decrement_to_acc: begin
                res    = mval - 8'h01;
                wr_mem = (st.op == mal_pkg::op_decrement);
                wr_acc = !wr_mem;
                zflag  = 1'b1;
            end
            default: res = 8'h00;
        endcase
        // a write to pc low costs a cycle
        if (ext) begin
            cycles = (tbl || skip || (wr_mem && st.m == mal_pkg::PC_LOW_ADDR))
                   ? mal_pkg::CYC_THREE : mal_pkg::CYC_TWO;
        end else begin
            cycles = (st.op == mal_pkg::op_call || (wr_mem && st.m == mal_pkg::PC_LOW_ADDR))
                   ? mal_pkg::CYC_TWO : mal_pkg::CYC_ONE;
        end
    end

    assign done = st.busy && (st.cnt == cycles - 2'h1);

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        nx     = st;
        dm_we  = 1'b0;
        dm_wa  = st.m;
        dm_wd  = res;
        pm_we  = 1'b0;
        nx.pready  = 1'b0;
        nx.pslverr = 1'b0;

        // watchdog stops while halted; set beats clear
        if (!st.halted) begin
            nx.watchdog_counter = st.watchdog_counter + 16'h0001;
        end

        if (st.busy) begin
            nx.cnt = st.cnt + 2'h1;
        end
        if (done) begin
            nx.busy = 1'b0;
            nx.cyc  = cycles;
            nx.skip = skip;
            nx.pc   = skip ? st.pc + 10'h002 : pc_inc;
            if (wr_acc) begin
                nx.acc = res;
            end
            if (wr_mem) begin
                if (st.m == mal_pkg::PC_LOW_ADDR) begin
                    nx.pc = {st.pc[9:8], res};
                end else begin
                    dm_we = 1'b1;
                end
            end
            if (arith) begin
                nx.fl.carry_flag           = add9[8];
                nx.fl.auxiliary_carry_flag = add5[4];
                nx.fl.overflow_flag        = ovf;
                nx.fl.signed_carry_flag    = add9[7] ^ ovf;
            end
            if (arith || zflag) begin
                nx.fl.zero_flag = (res == 8'h00);
            end
            if (tbl) begin
                nx.table_pointer    = tptr;
                nx.table_high_latch = tword[15:8];
            end
            case (st.op)
                mal_pkg::op_decimal_adjust_op: nx.fl.carry_flag = hi_adj;
                mal_pkg::op_call: begin
                    nx.stack[st.sp] = pc_inc;
                    nx.sp           = st.sp + 2'h1;
                    nx.pc           = st.target;
                end
                mal_pkg::op_clear_watchdog: begin
                    nx.watchdog_counter         = mal_pkg::WDOG_RST;
                    nx.fl.watchdog_timeout_flag = 1'b0;
                    nx.fl.power_down_flag       = 1'b0;
                end
                mal_pkg::op_power_down: begin
                    nx.halted                   = 1'b1;
                    nx.watchdog_counter         = mal_pkg::WDOG_RST;
                    nx.fl.watchdog_timeout_flag = 1'b0;
                    nx.fl.power_down_flag       = 1'b1;
                end
                default: nx.cnt = nx.cnt;
            endcase
        end
        if (!st.halted && st.watchdog_counter == 16'hffff) begin
            nx.fl.watchdog_timeout_flag = 1'b1;
        end

        // apb slave: one wait state, state writes other than maddr and paddr refused while busy
        if (access) begin
            nx.pready = 1'b1;
            nx.prdata = 32'h0000_0000;
            case (paddr)
                mal_pkg::ADDR_CMD: begin
                    if (pwrite) begin
                        nx.pslverr = !cmd_ok;
                        if (cmd_ok) begin
                            nx.op   = mal_pkg::mal_op_type'(pwdata[5:0]);
                            nx.bsel = pwdata[mal_pkg::CMD_BIT_LSB +: 3];
                            nx.busy = 1'b1;
                            nx.cnt  = 2'h0;
                        end
                    end else begin
                        nx.prdata = {21'h000000, st.bsel, 2'h0, st.op};
                    end
                end
                mal_pkg::ADDR_OPND: begin
                    if (pwrite && !st.busy) begin
                        nx.m      = pwdata[7:0];
                        nx.imm    = pwdata[mal_pkg::OPND_IMM_LSB +: 8];
                        nx.target = pwdata[mal_pkg::OPND_TGT_LSB +: 10];
                    end
                    nx.prdata = {6'h00, st.target, st.imm, st.m};
                end
                mal_pkg::ADDR_ACC: begin
                    if (pwrite && !st.busy) begin
                        nx.acc = pwdata[7:0];
                    end
                    nx.prdata = {24'h000000, st.acc};
                end
                mal_pkg::ADDR_STAT: begin
                    if (pwrite && !st.busy) begin
                        nx.fl.carry_flag           = pwdata[mal_pkg::ST_C];
                        nx.fl.auxiliary_carry_flag = pwdata[mal_pkg::ST_AUX];
                        nx.fl.zero_flag            = pwdata[mal_pkg::ST_Z];
                        nx.fl.overflow_flag        = pwdata[mal_pkg::ST_OVF];
                        nx.fl.signed_carry_flag    = pwdata[mal_pkg::ST_SGN];
                        nx.fl.power_down_flag      = pwdata[mal_pkg::ST_PDN];
                        if (pwdata[mal_pkg::ST_HLT]) begin
                            nx.halted = 1'b0;
                        end
                    end
                    nx.prdata = {21'h000000, st.skip, st.halted, st.busy, 1'b0,
                                 st.fl.power_down_flag, st.fl.watchdog_timeout_flag,
                                 st.fl.signed_carry_flag, st.fl.overflow_flag,
                                 st.fl.zero_flag, st.fl.auxiliary_carry_flag,
                                 st.fl.carry_flag};
                end
                mal_pkg::ADDR_PC: begin
                    if (pwrite && !st.busy) begin
                        nx.pc = pwdata[9:0];
                    end
                    nx.prdata = {20'h00000, st.sp, st.pc};
                end
                mal_pkg::ADDR_TBL: begin
                    if (pwrite && !st.busy) begin
                        nx.table_pointer = pwdata[7:0];
                        nx.table_page    = pwdata[mal_pkg::TBL_PAGE_LSB +: 2];
                    end
                    nx.prdata = {8'h00, st.table_high_latch, 6'h00, st.table_page,
                                 st.table_pointer};
                end
                mal_pkg::ADDR_MADDR: begin
                    if (pwrite) begin
                        nx.maddr = pwdata[7:0];
                    end
                    nx.prdata = {24'h000000, st.maddr};
                end
                mal_pkg::ADDR_MDATA: begin
                    if (pwrite && !st.busy) begin
                        dm_we = 1'b1;
                        dm_wa = st.maddr;
                        dm_wd = pwdata[7:0];
                    end
                    nx.prdata = {24'h000000, dmem[st.maddr]};
                end
                mal_pkg::ADDR_PADDR: begin
                    if (pwrite) begin
                        nx.pmaddr = pwdata[9:0];
                    end
                    nx.prdata = {22'h000000, st.pmaddr};
                end
                mal_pkg::ADDR_PDATA: begin
                    pm_we     = pwrite && !st.busy;
                    nx.prdata = {16'h0000, pmem[st.pmaddr]};
                end
                mal_pkg::ADDR_WDOG: nx.prdata = {16'h0000, st.watchdog_counter};
                mal_pkg::ADDR_CYC:  nx.prdata = {30'h00000000, st.cyc};
                default:            nx.pslverr = 1'b1;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers and memories

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st                  <= '0;
            st.acc              <= mal_pkg::ACC_RST;
            st.pc               <= mal_pkg::PC_RST;
            st.watchdog_counter <= mal_pkg::WDOG_RST;
        end else begin
            st <= nx;
        end
    end

    // memories carry no reset; software loads them before use
    always_ff @(posedge pclk) begin
        if (dm_we) begin
            dmem[dm_wa] <= dm_wd;
        end
        if (pm_we) begin
            pmem[st.pmaddr] <= pwdata[15:0];
        end
    end

    assign pready  = st.pready;
    assign prdata  = st.prdata;
    assign pslverr = st.pslverr;
    assign busy    = st.busy;
    assign halted  = st.halted;
endmodule : mal_core

// ==== verification/mal_monitor.sv ====
// concurrent checks on the ports of the instruction subset unit
`timescale 1ns/1ps
module mal_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        busy,
    input wire logic        halted
);
    logic took_cmd;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_take;
        psel && penable && !pready;
    endsequence
    sequence s_cmd;
        s_take ##0 (pwrite && paddr == mal_pkg::ADDR_CMD);
    endsequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            took_cmd <= 1'b0;
        else
            took_cmd <= psel && penable && !pready && pwrite && paddr == mal_pkg::ADDR_CMD;
    end
    ////////////////////////////////////////////////////////////////
    a_ready_one_wait: assert property (s_take |=> pready)
        else $error("pready missing after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr outside pready");
    a_unmapped_err: assert property (s_take ##0 (paddr > 8'h2c) |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_cmd_starts_busy: assert property (s_cmd ##0 (!busy && !halted) |=> busy && !pslverr)
        else $error("command did not start");
    a_cmd_when_halted: assert property (s_cmd ##0 halted |=> pslverr && !busy)
        else $error("command accepted while halted");
    a_busy_max_three: assert property (busy [*3] |=> !busy)
        else $error("busy longer than three cycles");
    a_busy_has_cause: assert property ($rose(busy) |-> took_cmd)
        else $error("busy without command");
    a_halt_holds: assert property (halted && !(psel && penable && pwrite
        && paddr == mal_pkg::ADDR_STAT && pwdata[9]) |=> halted)
        else $error("halt left without release write");
    a_halt_idle: assert property (halted |-> !busy)
        else $error("executing while halted");
endmodule : mal_monitor
bind mal_core mal_monitor mal_monitor_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .busy, .halted);

// ==== verification/mal_apb_master.sv ====
// apb master standing in for the software side of the unit
`timescale 1ns/1ps
module mal_apb_master (
    input wire logic        pclk,
    output logic            psel,
    output logic            penable,
    output logic            pwrite,
    output logic [7:0]      paddr,
    output logic [31:0]     pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'hff;
        pwdata = 32'h0;
    end
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : mal_apb_master

// ==== verification/tb_mal_core.sv ====
// self-checking bench of the instruction subset unit
`timescale 1ns/1ps
module tb_mal_core;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, halted, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q, e_st, seed;
    logic [1:0]  spv;
    int          error_cnt, check_count, e_acc, e_mem, e_cyc, e_skp, r, a, mv, st, b, imm, w;
    mal_core mal_core_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .busy, .halted);
    mal_apb_master mal_apb_master_inst (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr);
    ////////////////////////////////////////////////////////////////
    function automatic int rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return int'(seed & 32'h7fffffff);
    endfunction : rnd
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
            error_cnt++;
        end
    endtask : chk
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        mal_apb_master_inst.xfer(1'b1, ad, d, q, err);
    endtask : wr
    task automatic rd(input logic [7:0] ad);
        mal_apb_master_inst.xfer(1'b0, ad, 32'h0, q, err);
    endtask : rd
    task automatic wt();
        for (int i = 0; i < 9 && busy !== 1'b0; i++) @(posedge pclk);
    endtask : wt
    ////////////////////////////////////////////////////////////////
    function automatic void model(int o);
        int x, c, ov;
        x = (o == 22 || o == 25) ? imm : mv;
        c = (o == 18 || o == 19) ? st & 1 : 0;
        e_acc = a;
        e_mem = mv;
        e_st = 32'(st);
        e_skp = 0;
        r = 0;
        case (o)
            1, 3: e_skp = (mv == 0) != (o == 3);
            2: e_skp = mv == 0;
            4, 5: e_skp = ((mv >> b) & 1) == o - 4;
            6, 8: r = (mv + 1) & 255;
            7, 9, 33, 34: r = (mv + 255) & 255;
            15: r = 255;
            16, 17: r = ((mv << 4) | (mv >> 4)) & 255;
            18, 19, 20, 21, 22: r = a + x + c;
            23, 24, 25: r = a & x;
            28: r = mv & ~(1 << b);
            30, 31: r = ~mv & 255;
            32: r = a + ((a & 15) > 9 || st & 2 ? 6 : 0) + (a > 159 || st & 1 ? 96 : 0);
            default: r = 0;
        endcase
        if (o == 2) e_acc = mv;
        if (o inside {8, 9, 17, 18, 20, 22, 23, 25, 31, 34}) e_acc = r & 255;
        if (o inside {6, 7, 14, 15, 16, 19, 21, 24, 27, 28, 30, 32, 33}) e_mem = r & 255;
        if (o inside {[6:9]}) e_skp = (r & 255) == 0;
        if (o > 17 && o < 23) begin
            ov = ((a ^ r) & (x ^ r) & 128) != 0;
            e_st[mal_pkg::ST_C] = r > 255;
            e_st[mal_pkg::ST_AUX] = (a & 15) + (x & 15) + c > 15;
            e_st[mal_pkg::ST_OVF] = ov;
            e_st[mal_pkg::ST_SGN] = r[7] ^ ov;
        end
        if (o inside {[18:25], 30, 31, 33, 34}) e_st[mal_pkg::ST_Z] = (r & 255) == 0;
        if (o == 32) e_st[mal_pkg::ST_C] = a > 159 || st & 1;
        e_cyc = (o > 0 && o < 18 ? 2 : 1) + e_skp;
    endfunction : model
    task automatic run(input int o, input logic [7:0] m);
        wr(mal_pkg::ADDR_MADDR, 32'(m));
        wr(mal_pkg::ADDR_MDATA, 32'(mv));
        wr(mal_pkg::ADDR_ACC, 32'(a));
        wr(mal_pkg::ADDR_STAT, 32'(st));
        wr(mal_pkg::ADDR_OPND, 32'(imm * 256 + m));
        wr(mal_pkg::ADDR_CMD, 32'(b * 256 + o));
        wt();
        model(o);
        if (m == mal_pkg::PC_LOW_ADDR) e_cyc = 3;
        rd(mal_pkg::ADDR_ACC);
        chk(q, 32'(e_acc));
        rd(mal_pkg::ADDR_STAT);
        chk(q & 32'h41f, 32'(e_skp << 10) | e_st);
        rd(mal_pkg::ADDR_CYC);
        chk(q, 32'(e_cyc));
        rd(mal_pkg::ADDR_MDATA);
        if (m != mal_pkg::PC_LOW_ADDR) chk(q, 32'(e_mem));
    endtask : run
    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        repeat (30000) @(posedge pclk);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        seed = 32'h0e892c28;
        presetn = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int p = 0; p < 4; p++) begin
            for (int o = 0; o < 35; o++) begin
                if (o inside {[10:13], 26, 29}) continue;
                a = rnd() & 255;
                st = rnd() & 31;
                b = rnd() & 7;
                imm = rnd() & 255;
                mv = p == 0 ? rnd() & 255 : p == 1 ? 0 : p == 2 ? 255 : 1;
                run(o, 8'h40);
            end
        end
        for (int o = 10; o < 14; o++) begin
            w = rnd() & 16'hffff;
            wr(mal_pkg::ADDR_PADDR, 32'((o & 1 ? 768 : 256) + 16 + (o > 11)));
            wr(mal_pkg::ADDR_PDATA, 32'(w));
            wr(mal_pkg::ADDR_TBL, 32'h110);
            wr(mal_pkg::ADDR_CMD, 32'(o));
            wt();
            rd(mal_pkg::ADDR_MDATA);
            chk(q, 32'(w & 255));
            rd(mal_pkg::ADDR_TBL);
            chk(q & 32'hff00ff, 32'(((w >> 8) << 16) + 16 + (o > 11)));
            rd(mal_pkg::ADDR_CYC);
            chk(q, 32'h3);
        end
        run(14, mal_pkg::PC_LOW_ADDR);
        rd(mal_pkg::ADDR_PC);
        spv = q[11:10] + 2'h1;
        wr(mal_pkg::ADDR_OPND, 32'h2a30000);
        wr(mal_pkg::ADDR_CMD, 32'd26);
        wt();
        rd(mal_pkg::ADDR_PC);
        chk(q & 32'hfff, {20'h0, spv, 10'h2a3});
        wr(mal_pkg::ADDR_CMD, 32'd35);
        wt();
        chk(32'(halted), 32'h1);
        rd(mal_pkg::ADDR_STAT);
        chk(q & 32'h60, 32'h40);
        wr(mal_pkg::ADDR_CMD, 32'h0);
        chk(32'(err), 32'h1);
        wr(mal_pkg::ADDR_STAT, 32'h240);
        wr(mal_pkg::ADDR_CMD, 32'd29);
        wt();
        rd(mal_pkg::ADDR_STAT);
        chk(q & 32'h60, 32'h0);
        rd(mal_pkg::ADDR_WDOG);
        chk(q & 32'hffe0, 32'h0);
        rd(8'h30);
        chk({q[30:0], err}, 32'h1);
        report_and_stop();
    end
endmodule : tb_mal_core
